// *** pitp_cfg.svh ***
// offsets, field positions, reset values and timing counts of the thermostat block
`ifndef PITP_CFG_SVH
`define PITP_CFG_SVH
`define PITP_OFF_CTRL 12'h000
`define PITP_OFF_HCIN 12'h004
`define PITP_OFF_OPMODE 12'h008
`define PITP_OFF_PBAND 12'h00C
`define PITP_OFF_ITIME 12'h010
`define PITP_OFF_PERIOD 12'h014
`define PITP_OFF_STAT 12'h018
`define PITP_OFF_CV 12'h01C
`define PITP_OFF_SP_BASE 12'h020
`define PITP_OFF_TEMP 12'h050
`define PITP_NSP 11
`define PITP_SP_IN 4'h0
`define PITP_SP_DEF_H 4'h1
`define PITP_SP_DEF_C 4'h2
`define PITP_SP_COMF_H 4'h3
`define PITP_SP_COMF_C 4'h4
`define PITP_SP_STBY_H 4'h5
`define PITP_SP_STBY_C 4'h6
`define PITP_SP_ECO_H 4'h7
`define PITP_SP_ECO_C 4'h8
`define PITP_SP_PROT_H 4'h9
`define PITP_SP_PROT_C 4'hA
`define PITP_CTRL_MGMT 1:0
`define PITP_CTRL_HEAT_EN 2
`define PITP_CTRL_COOL_EN 3
`define PITP_CTRL_WIN_EN 4
`define PITP_CTRL_AUTO_SW 5
`define PITP_CTRL_PWM_EN 6
`define PITP_CTRL_RST 7'h44
`define PITP_PBAND_RST 16'h0050
`define PITP_ITIME_RST 10'h096
`define PITP_PERIOD_RST 8'h0F
`define PITP_SP_RST_IN 16'h0140
`define PITP_SP_RST_DEF_H 16'h0140
`define PITP_SP_RST_DEF_C 16'h0180
`define PITP_SP_RST_COMF_H 16'h0140
`define PITP_SP_RST_COMF_C 16'h0180
`define PITP_SP_RST_STBY_H 16'hFFE0
`define PITP_SP_RST_STBY_C 16'h0020
`define PITP_SP_RST_ECO_H 16'hFFC0
`define PITP_SP_RST_ECO_C 16'h0040
`define PITP_SP_RST_PROT_H 16'h0070
`define PITP_SP_RST_PROT_C 16'h0230
`define PITP_PCT_FULL 16'h6400
`define PITP_PCT_SCALE 32'h00006400
`define PITP_SEC_PER_MIN 16'h003C
`define PITP_CLK_HZ 25000000
`define PITP_SAMPLE_S 1
`define PITP_TICK_CYCLES (`PITP_CLK_HZ * `PITP_SAMPLE_S)
`define PITP_TICK_W 25
`endif

// *** pitp_pkg.sv ***
// types shared by the thermostat block
package pitp_pkg;
   typedef enum logic [1:0] {
      PITP_MGMT_SINGLE = 2'h0,
      PITP_MGMT_REL = 2'h1,
      PITP_MGMT_ABS = 2'h2
   } pitp_mgmt_t;
   typedef enum logic [1:0] {
      PITP_OPM_COMFORT = 2'h0,
      PITP_OPM_STANDBY = 2'h1,
      PITP_OPM_ECONOMY = 2'h2,
      PITP_OPM_PROTECT = 2'h3
   } pitp_opmode_t;
   typedef enum logic [1:0] {
      PITP_ST_IDLE = 2'b00,
      PITP_ST_DIVP = 2'b01,
      PITP_ST_DIVI = 2'b11,
      PITP_ST_UPD = 2'b10
   } pitp_state_t;
endpackage

// *** pitp_top.sv ***
// pi room thermostat: setpoint selection, pi control variable and pwm actuator drive
//
// Summary of operation
// - error is setpoint minus temp heating, reversed cooling
// - control variable is proportional plus integral term
// - proportional gain is hundred over proportional band
// - integral gain is proportional gain over integral time
// - error equal to band gives full scale
// - pwm on time proportional to control variable
// - setpoint change restarts pwm cycle immediately
// - single setpoint input kept in nonvolatile storage
// - unwritten input uses default heating or cooling setpoints
// - heat/cool status input selects controller action
// - open window freezes input, applies protection setpoint
// - relative mode stores every written value nonvolatile
// - operating mode input selects mode, comfort default
// - absolute mode exposes four absolute setpoints
// - four mutually exclusive operating modes
// - single mode has setpoint and protection only
// - separate heating and cooling values kept
// - setpoints accessible except during automatic switch-over
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns
`include "pitp_cfg.svh"
`default_nettype none
module pitp_top
   import pitp_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `PITP_TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [15:0] temp_meas,
   input wire logic window_open,
   output logic valve_on,
   output logic [15:0] control_pct,
   output logic nv_wr,
   output logic [3:0] nv_idx,
   output logic [15:0] nv_data
);

   // temperatures are signed, 1/16 K per lsb; percent values carry 8 fraction bits

   function automatic logic [15:0] sel_hc(input logic heat, input logic [15:0] h,
                                          input logic [15:0] c);
      sel_hc = heat ? h : c;
   endfunction

   function automatic logic [15:0] sp_rst(input int idx);
      case (idx)
         0: sp_rst = `PITP_SP_RST_IN;
         1: sp_rst = `PITP_SP_RST_DEF_H;
         2: sp_rst = `PITP_SP_RST_DEF_C;
         3: sp_rst = `PITP_SP_RST_COMF_H;
         4: sp_rst = `PITP_SP_RST_COMF_C;
         5: sp_rst = `PITP_SP_RST_STBY_H;
         6: sp_rst = `PITP_SP_RST_STBY_C;
         7: sp_rst = `PITP_SP_RST_ECO_H;
         8: sp_rst = `PITP_SP_RST_ECO_C;
         9: sp_rst = `PITP_SP_RST_PROT_H;
         default: sp_rst = `PITP_SP_RST_PROT_C;
      endcase
   endfunction

   // ---------------- register bus ----------------
   logic [6:0] ctrl_q;
   logic hc_heat_q;
   logic [1:0] opm_q;
   logic opm_wr_q;
   logic sp_in_wr_q;
   logic [15:0] pband_q;
   logic [9:0] itime_q;
   logic [7:0] period_q;
   logic [15:0] sp_q [`PITP_NSP];
   logic [31:0] prdata_q;
   logic pslverr_q;

   wire acc = psel & penable;
   wire setup = psel & ~penable;
   wire wr = acc & pwrite;
   wire [11:0] sp_off = paddr - `PITP_OFF_SP_BASE;
   wire [3:0] sp_sel = sp_off[5:2];
   wire sp_hit = (paddr >= `PITP_OFF_SP_BASE) && (sp_sel < 4'(`PITP_NSP))
                 && (sp_off[11:6] == 6'h00) && (paddr[1:0] == 2'h0);
   wire auto_sw = ctrl_q[`PITP_CTRL_AUTO_SW];
   wire sp_blocked = sp_hit & auto_sw;
   wire reg_hit = (paddr <= `PITP_OFF_CV) && (paddr[1:0] == 2'h0);
   wire tmp_hit = (paddr == `PITP_OFF_TEMP);
   wire bad_addr = ~(reg_hit | tmp_hit | sp_hit);
   wire mgmt_single = (ctrl_q[`PITP_CTRL_MGMT] == PITP_MGMT_SINGLE);
   wire mgmt_rel = (ctrl_q[`PITP_CTRL_MGMT] == PITP_MGMT_REL);
   wire heat_en = ctrl_q[`PITP_CTRL_HEAT_EN];
   wire cool_en = ctrl_q[`PITP_CTRL_COOL_EN];
   wire win_freeze = ctrl_q[`PITP_CTRL_WIN_EN] & window_open;
   // the input setpoint ignores writes while frozen by an open window
   wire sp_in_lock = win_freeze & (sp_sel == `PITP_SP_IN);
   wire sp_wr = wr & sp_hit & ~sp_blocked & ~sp_in_lock;
   wire nv_keep = mgmt_rel | (mgmt_single & (sp_sel == `PITP_SP_IN));

   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= `PITP_CTRL_RST;
         hc_heat_q <= 1'b1;
         opm_q <= PITP_OPM_COMFORT;
         opm_wr_q <= 1'b0;
         pband_q <= `PITP_PBAND_RST;
         itime_q <= `PITP_ITIME_RST;
         period_q <= `PITP_PERIOD_RST;
      end else if (wr) begin
         case (paddr)
            `PITP_OFF_CTRL: ctrl_q <= pwdata[6:0];
            `PITP_OFF_HCIN: hc_heat_q <= pwdata[0];
            `PITP_OFF_OPMODE: begin
               opm_q <= pwdata[1:0];
               opm_wr_q <= 1'b1;
            end
            // a zero band would divide by zero and a zero period would keep the valve off, so the least value is 1
            `PITP_OFF_PBAND: pband_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
            `PITP_OFF_ITIME: itime_q <= pwdata[9:0];
            `PITP_OFF_PERIOD: period_q <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
            default: ;
         endcase
      end
   end

   // setpoint and offset slots, heating and cooling kept apart
   genvar gi;
   generate
      for (gi = 0; gi < `PITP_NSP; gi++) begin : g_sp
         always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
               sp_q[gi] <= sp_rst(gi);
            end else if (sp_wr && (sp_sel == 4'(gi))) begin
               sp_q[gi] <= pwdata[15:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sp_in_wr_q <= 1'b0;
      end else if (sp_wr && (sp_sel == `PITP_SP_IN)) begin
         sp_in_wr_q <= 1'b1;
      end
   end

   // store request toward the external non-volatile memory, one pulse per slot write in relative mode or input slot write in single mode
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         nv_wr <= 1'b0;
         nv_idx <= 4'h0;
         nv_data <= 16'h0000;
      end else begin
         nv_wr <= sp_wr & nv_keep;
         if (sp_wr) begin
            nv_idx <= sp_sel;
            nv_data <= pwdata[15:0];
         end
      end
   end

   // ---------------- setpoint selection ----------------
   wire heat_act = (heat_en & cool_en) ? hc_heat_q : heat_en;
   wire ctl_en = heat_en | cool_en;
   logic [1:0] eff_opm;
   logic [15:0] sp_act;
   wire [15:0] comf = sel_hc(heat_act, sp_q[`PITP_SP_COMF_H], sp_q[`PITP_SP_COMF_C]);
   wire [15:0] stby = sel_hc(heat_act, sp_q[`PITP_SP_STBY_H], sp_q[`PITP_SP_STBY_C]);
   wire [15:0] eco = sel_hc(heat_act, sp_q[`PITP_SP_ECO_H], sp_q[`PITP_SP_ECO_C]);
   wire [15:0] prot = sel_hc(heat_act, sp_q[`PITP_SP_PROT_H], sp_q[`PITP_SP_PROT_C]);
   wire [15:0] dflt = sel_hc(heat_act, sp_q[`PITP_SP_DEF_H], sp_q[`PITP_SP_DEF_C]);
   wire [1:0] opm_sel = opm_wr_q ? opm_q : PITP_OPM_COMFORT;

   always_comb begin
      if (win_freeze) begin
         eff_opm = PITP_OPM_PROTECT;
      end else if (mgmt_single) begin
         eff_opm = PITP_OPM_COMFORT;
      end else begin
         eff_opm = opm_sel;
      end
   end

   always_comb begin
      case (eff_opm)
         PITP_OPM_PROTECT: sp_act = prot;
         PITP_OPM_STANDBY: sp_act = mgmt_rel ? comf + stby : stby;
         PITP_OPM_ECONOMY: sp_act = mgmt_rel ? comf + eco : eco;
         default: begin
            if (mgmt_single) begin
               sp_act = sp_in_wr_q ? sp_q[`PITP_SP_IN] : dflt;
            end else begin
               sp_act = comf;
            end
         end
      endcase
   end

   // ---------------- timebase ----------------
   logic [`PITP_TICK_W-1:0] pre_q;
   logic tick_q;
   logic [15:0] sp_last_q;
   logic restart_q;
   logic rs_run_q;
   logic calc_start;
   logic calc_done;
   wire sp_change = (sp_act != sp_last_q);
   // only a computation started after the change may restart the pwm cycle
   wire restart_now = rs_run_q & calc_done;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         pre_q <= '0;
         tick_q <= 1'b0;
      end else if (restart_now || pre_q == `PITP_TICK_W'(TICK_CYCLES - 1)) begin
         pre_q <= '0;
         tick_q <= ~restart_now;
      end else begin
         pre_q <= pre_q + 1'b1;
         tick_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sp_last_q <= 16'h0000;
         restart_q <= 1'b1;
         rs_run_q <= 1'b0;
      end else begin
         sp_last_q <= sp_act;
         if (sp_change) begin
            restart_q <= 1'b1;
         end else if (calc_start) begin
            restart_q <= 1'b0;
         end
         if (calc_start) begin
            rs_run_q <= restart_q;
         end else if (calc_done) begin
            rs_run_q <= 1'b0;
         end
      end
   end

   // ---------------- pi computation ----------------
   pitp_state_t st_q;
   logic [16:0] rem_q;
   logic [31:0] quo_q;
   logic [15:0] den_q;
   logic [4:0] it_q;
   logic integ_pend_q;
   logic [15:0] p_mag_q;
   logic p_neg_q;
   logic signed [31:0] integ_q;
   logic [15:0] cv_q;
   logic sat_hi_q;
   logic sat_lo_q;

   wire signed [16:0] t_s = 17'(signed'(temp_meas));
   wire signed [16:0] sp_s = 17'(signed'(sp_act));
   wire signed [16:0] err = heat_act ? sp_s - t_s : t_s - sp_s;
   wire err_neg = err[16];
   wire [16:0] err_abs = err_neg ? 17'(-err) : 17'(err);
   wire [15:0] err_mag = err_abs[16] ? 16'hFFFF : err_abs[15:0];
   // gain 100/band: p% = 100 * err / band, so err == band reads as full scale
   wire [31:0] p_num = 32'(err_mag) * `PITP_PCT_SCALE;
   wire [16:0] div_try = {rem_q[15:0], quo_q[31]};
   wire div_ge = (div_try >= {1'b0, den_q});
   // quotient including the step taken at this edge, so no bit is lost at the hand-over
   wire [31:0] q_fin = {quo_q[30:0], div_ge};
   // integral gain kp/ti scaled for a one-second sample: p * 2^16 / (60 * ti)
   wire [15:0] i_den = 16'(32'(itime_q) * 32'(`PITP_SEC_PER_MIN));
   wire [31:0] p_big = (q_fin > 32'(2 * `PITP_PCT_FULL)) ? 32'(2 * `PITP_PCT_FULL) : q_fin;
   wire [15:0] p_lim = (p_big > 32'(`PITP_PCT_FULL)) ? `PITP_PCT_FULL : p_big[15:0];
   wire signed [31:0] inc = p_neg_q ? -signed'(quo_q) : signed'(quo_q);
   wire inc_ok = !(sat_hi_q && !p_neg_q) && !(sat_lo_q && p_neg_q);
   wire signed [31:0] integ_max = signed'({8'h00, `PITP_PCT_FULL, 8'h00}) <<< 8;
   wire signed [32:0] integ_sum = 33'(integ_q) + 33'(inc);
   wire signed [31:0] integ_nxt = (integ_sum > 33'(integ_max)) ? integ_max :
                                  (integ_sum < -33'(integ_max)) ? -integ_max :
                                  integ_sum[31:0];
   wire signed [17:0] p_term = p_neg_q ? -18'(p_mag_q) : 18'(p_mag_q);
   wire signed [18:0] cv_raw = 19'(p_term) + 19'(integ_q >>> 16);
   wire cv_hi = cv_raw > 19'sh06400;
   wire cv_lo = cv_raw < 19'sd0;
   wire [15:0] cv_clip = cv_hi ? `PITP_PCT_FULL : (cv_lo ? 16'h0000 : cv_raw[15:0]);

   assign calc_done = (st_q == PITP_ST_UPD);
   assign calc_start = (st_q == PITP_ST_IDLE) & (tick_q | restart_q);
   assign control_pct = cv_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_q <= PITP_ST_IDLE;
         rem_q <= '0;
         quo_q <= '0;
         den_q <= 16'h0001;
         it_q <= '0;
         integ_pend_q <= 1'b0;
         p_mag_q <= '0;
         p_neg_q <= 1'b0;
      end else begin
         case (st_q)
            PITP_ST_IDLE: begin
               if (tick_q || restart_q) begin
                  st_q <= PITP_ST_DIVP;
                  integ_pend_q <= tick_q;
                  rem_q <= '0;
                  quo_q <= p_num;
                  den_q <= pband_q;
                  p_neg_q <= err_neg;
                  it_q <= '0;
               end
            end
            PITP_ST_DIVP, PITP_ST_DIVI: begin
               rem_q <= div_ge ? div_try - {1'b0, den_q} : div_try;
               quo_q <= q_fin;
               it_q <= it_q + 1'b1;
               if (it_q == 5'h1F && st_q == PITP_ST_DIVP) begin
                  // second division starts from the finished proportional magnitude
                  st_q <= PITP_ST_DIVI;
                  p_mag_q <= p_big[15:0];
                  rem_q <= '0;
                  quo_q <= {p_lim, 16'h0000};
                  den_q <= i_den;
               end else if (it_q == 5'h1F) begin
                  st_q <= PITP_ST_UPD;
               end
            end
            PITP_ST_UPD: st_q <= PITP_ST_IDLE;
            default: st_q <= PITP_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         integ_q <= '0;
         cv_q <= 16'h0000;
         sat_hi_q <= 1'b0;
         sat_lo_q <= 1'b0;
      end else if (calc_done) begin
         if (itime_q == 10'h000 || !ctl_en) begin
            integ_q <= '0;
         end else if (integ_pend_q && inc_ok) begin
            integ_q <= integ_nxt;
         end
         cv_q <= ctl_en ? cv_clip : 16'h0000;
         sat_hi_q <= cv_hi;
         sat_lo_q <= cv_lo;
      end
   end

   // ---------------- pwm ----------------
   logic [15:0] sec_q;
   wire [15:0] period_s = 16'(32'(period_q) * 32'(`PITP_SEC_PER_MIN));
   // compare scaled products instead of dividing for the on time
   wire [31:0] pos_scaled = 32'(sec_q) * `PITP_PCT_SCALE;
   wire [31:0] on_scaled = 32'(cv_q) * 32'(period_s);
   wire pwm_on = (pos_scaled < on_scaled) & ctrl_q[`PITP_CTRL_PWM_EN];

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sec_q <= 16'h0000;
         valve_on <= 1'b0;
      end else begin
         if (restart_now) begin
            sec_q <= 16'h0000;
         end else if (tick_q) begin
            sec_q <= (sec_q >= period_s - 16'h0001) ? 16'h0000 : sec_q + 16'h0001;
         end
         valve_on <= pwm_on & ~(restart_q | rs_run_q);
      end
   end

   // ---------------- read path ----------------
   logic [31:0] rd_d;
   wire [7:0] stat = {opm_wr_q, sp_in_wr_q, eff_opm, win_freeze, sat_hi_q | sat_lo_q,
                      heat_act, valve_on};

   always_comb begin
      rd_d = 32'h0000_0000;
      if (sp_hit) begin
         rd_d = sp_blocked ? 32'h0000_0000 : {16'h0000, sp_q[sp_sel]};
      end else begin
         case (paddr)
            `PITP_OFF_CTRL: rd_d = {25'h0, ctrl_q};
            `PITP_OFF_HCIN: rd_d = {31'h0, hc_heat_q};
            `PITP_OFF_OPMODE: rd_d = {30'h0, opm_q};
            `PITP_OFF_PBAND: rd_d = {16'h0, pband_q};
            `PITP_OFF_ITIME: rd_d = {22'h0, itime_q};
            `PITP_OFF_PERIOD: rd_d = {24'h0, period_q};
            `PITP_OFF_STAT: rd_d = {24'h0, stat};
            `PITP_OFF_CV: rd_d = {sp_act, cv_q};
            `PITP_OFF_TEMP: rd_d = {16'h0, temp_meas};
            default: rd_d = 32'h0000_0000;
         endcase
      end
   end

   // captured in the setup cycle so the access phase answers from flip-flops
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
         pslverr_q <= bad_addr | sp_blocked;
      end
   end

endmodule // pitp_top
`default_nettype wire

// *** pitp_top_monitor.sv ***
// port-level assertions of the thermostat block
`timescale 1ns/1ns
`default_nettype none
module pitp_top_monitor (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [15:0] temp_meas,
   input wire logic window_open,
   input wire logic valve_on,
   input wire logic [15:0] control_pct,
   input wire logic nv_wr,
   input wire logic [3:0] nv_idx,
   input wire logic [15:0] nv_data
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_wr_access;
      psel && penable && pwrite;
   endsequence
   a_no_wait: assert property (s_setup |=> pready)
      else $error("setup not answered at once");
   a_unmapped_err: assert property (s_setup ##0 (paddr > 12'h050) |=> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (s_setup ##0 (paddr < 12'h020 && paddr[1:0] == 2'h0) |=> !pslverr)
      else $error("mapped register refused");
   a_temp_read: assert property (s_setup ##0 (paddr == 12'h050 && !pwrite) |=> prdata[15:0] == $past(temp_meas))
      else $error("temperature read differs from input");
   a_nv_pulse: assert property (nv_wr |=> !nv_wr)
      else $error("store pulse longer than one cycle");
   a_nv_cause: assert property (nv_wr |-> $past(psel && penable && pwrite) && nv_idx <= 4'hA)
      else $error("store without a setpoint write");
   a_nv_data: assert property (nv_wr |-> nv_data == $past(pwdata[15:0]))
      else $error("stored value differs from written word");
   a_pct_range: assert property (control_pct <= 16'h6400)
      else $error("control variable above full scale");
   a_valve_idle: assert property ($past(control_pct) == 16'h0 |-> !valve_on)
      else $error("valve on with zero control variable");
   c_store: cover property (s_wr_access ##1 nv_wr);
endmodule // pitp_top_monitor
bind pitp_top pitp_top_monitor i_mon (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .temp_meas, .window_open, .valve_on, .control_pct,
   .nv_wr, .nv_idx, .nv_data);
`default_nettype wire

// *** pitp_nv_partner.sv ***
// nonvolatile store and on/off actuator on the far side of the thermostat
`timescale 1ns/1ns
`default_nettype none
module pitp_nv_partner (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic nv_wr,
   input wire logic [3:0] nv_idx,
   input wire logic [15:0] nv_data,
   input wire logic valve_on,
   output var logic [3:0] last_idx,
   output var logic [15:0] last_data,
   output int stores,
   output int on_cycles
);
   initial begin
      last_idx = 4'h0;
      last_data = 16'h0;
      stores = 0;
      on_cycles = 0;
   end
   // the store keeps its content through reset, as a real memory does
   always @(posedge mclk) begin
      if (resetn && nv_wr === 1'b1) begin
         last_idx <= nv_idx;
         last_data <= nv_data;
         stores <= stores + 1;
      end
      if (resetn && valve_on === 1'b1) begin
         on_cycles <= on_cycles + 1;
      end
   end
endmodule // pitp_nv_partner
`default_nettype wire

// *** pitp_top_test.sv ***
// self-checking bench of the thermostat block
`timescale 1ns/1ns
`default_nettype none
module pitp_top_test;
   import pitp_pkg::*;
   localparam int TICK = 100;
   localparam int FULL = 32'h6400;
   logic mclk, resetn, psel, penable, pwrite, window_open, pready, pslverr, valve_on, nv_wr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [15:0] temp_meas, control_pct, nv_data, last_data;
   logic [3:0] nv_idx, last_idx;
   int stores, on_cycles, err_count, samples_checked, v, n, e, sp, sp_m[11];
   int cyc = 0;
   int reg_rst[6] = '{32'h44, 32'h1, 32'h0, 32'h50, 32'h96, 32'hF};
   int sp_rst[11] = '{32'h140, 32'h140, 32'h180, 32'h140, 32'h180, 32'hFFE0, 32'h20,
      32'hFFC0, 32'h40, 32'h70, 32'h230};
   // ctrl, opmode, window, heat/cool, expected active setpoint
   logic [35:0] sel_tab[7] = '{36'h48_0_0_0_0180, 36'h58_0_1_0_0230, 36'h45_0_0_1_0140,
      36'h45_1_0_1_0120, 36'h45_2_0_1_0100, 36'h45_3_0_1_0070, 36'h4D_0_0_0_0180};
   // heat/cool, band, error; the last case leaves 50 percent for the pwm checks
   logic [31:0] ctl_tab[8] = '{32'h1_050_0028, 32'h1_050_0050, 32'h1_050_00A0, 32'h1_028_0028,
      32'h1_0A0_0028, 32'h0_050_0028, 32'h1_050_FFD8, 32'h1_050_0028};
   pitp_top #(.TICK_CYCLES(TICK)) i_dut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .temp_meas, .window_open, .valve_on, .control_pct,
      .nv_wr, .nv_idx, .nv_data);
   pitp_nv_partner i_nv (.mclk, .resetn, .nv_wr, .nv_idx, .nv_data, .valve_on, .last_idx,
      .last_data, .stores, .on_cycles);
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   function automatic int p_model(input int er, input int pb);
      int p;
      p = er * FULL / pb;
      if (p > FULL) p = FULL;
      if (p < 0) p = 0;
      return p;
   endfunction
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         err_count++;
         end_of_test();
      end
   end
   initial begin
      {resetn, psel, penable, pwrite, window_open} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      temp_meas = 16'h0;
      err_count = 0;
      samples_checked = 0;
      v = $urandom(32'h5EAB84C3);
      repeat (2) @(posedge mclk);
      resetn <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         apb(1'b0, 12'(4 * i), 32'h0);
         check("register reset", rd, reg_rst[i]);
      end
      for (int i = 0; i < 11; i++) begin
         apb(1'b0, 12'(32 + 4 * i), 32'h0);
         check("slot reset", rd, sp_rst[i]);
      end
      $display("reset image test done");
      foreach (sel_tab[i]) begin
         window_open <= sel_tab[i][20];
         apb(1'b1, 12'h004, {31'h0, sel_tab[i][16]});
         apb(1'b1, 12'h008, {30'h0, sel_tab[i][25:24]});
         apb(1'b1, 12'h000, {24'h0, sel_tab[i][35:28]});
         repeat (TICK + 80) @(posedge mclk);
         apb(1'b0, 12'h01C, 32'h0);
         check("active setpoint", {16'h0, rd[31:16]}, {16'h0, sel_tab[i][15:0]});
      end
      window_open <= 1'b0;
      $display("setpoint selection test done");
      apb(1'b0, 12'h100, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      apb(1'b1, 12'h000, 32'h65);
      apb(1'b0, 12'h02C, 32'h0);
      check("locked slot error", {31'h0, err}, 32'h1);
      apb(1'b1, 12'h000, 32'h45);
      n = stores;
      for (int i = 0; i < 11; i++) begin
         sp_m[i] = $urandom_range(32'h300, 32'h100);
         apb(1'b1, 12'(32 + 4 * i), sp_m[i]);
         repeat (2) @(posedge mclk);
         n++;
         check("store count", stores, n);
         check("store slot", {28'h0, last_idx}, i);
         check("store value", {16'h0, last_data}, sp_m[i]);
      end
      for (int i = 0; i < 11; i++) begin
         apb(1'b0, 12'(32 + 4 * i), 32'h0);
         check("slot readback", rd, sp_m[i]);
      end
      apb(1'b1, 12'h000, 32'h44);
      apb(1'b1, 12'h02C, 32'h155);
      repeat (2) @(posedge mclk);
      check("no store in single mode", stores, n);
      apb(1'b1, 12'h000, 32'h54);
      window_open <= 1'b1;
      apb(1'b1, 12'h020, 32'h155);
      repeat (2) @(posedge mclk);
      check("frozen input store", stores, n);
      window_open <= 1'b0;
      apb(1'b1, 12'h020, 32'h155);
      repeat (2) @(posedge mclk);
      check("input setpoint store", stores, n + 1);
      $display("store test done");
      // both actions off clears the integral, integral time 0 leaves the proportional part
      apb(1'b1, 12'h000, 32'h1);
      apb(1'b1, 12'h010, 32'h0);
      apb(1'b1, 12'h008, 32'h0);
      repeat (TICK + 80) @(posedge mclk);
      check("idle output", {16'h0, control_pct}, 32'h0);
      apb(1'b1, 12'h014, 32'h1);
      apb(1'b1, 12'h000, 32'h4D);
      foreach (ctl_tab[i]) begin
         e = $signed(ctl_tab[i][15:0]);
         sp = 32'h140 + 16 * i;
         apb(1'b1, 12'h004, {31'h0, ctl_tab[i][28]});
         apb(1'b1, 12'h00C, {20'h0, ctl_tab[i][27:16]});
         temp_meas <= ctl_tab[i][28] ? 16'(sp - e) : 16'(sp + e);
         apb(1'b1, ctl_tab[i][28] ? 12'h02C : 12'h030, sp);
         repeat (TICK + 80) @(posedge mclk);
         check("control output", {16'h0, control_pct}, p_model(e, ctl_tab[i][27:16]));
      end
      $display("control test done");
      temp_meas <= 16'h1D8;
      apb(1'b1, 12'h02C, 32'h200);
      repeat (3) @(posedge mclk);
      check("valve during restart", {31'h0, valve_on}, 32'h0);
      repeat (80) @(posedge mclk);
      n = on_cycles;
      repeat (60 * TICK) @(posedge mclk);
      check("pwm on share", (on_cycles - n + 50) / 100, 30);
      repeat (4000) @(posedge mclk);
      check("valve in off phase", {31'h0, valve_on}, 32'h0);
      temp_meas <= 16'h1E8;
      apb(1'b1, 12'h02C, 32'h210);
      repeat (150) @(posedge mclk);
      check("valve after restart", {31'h0, valve_on}, 32'h1);
      $display("pwm test done");
      end_of_test();
   end
endmodule // pitp_top_test
`default_nettype wire
